// ===== pwmct_defines.vh
/*
 pwmct_defines.vh: register offsets, field positions, reset values and
 encodings of the pwm channel with comparator trip.
 assumes: included by bare name; definitions only.
*/
`ifndef PWMCT_DEFINES_VH
`define PWMCT_DEFINES_VH

// printed offsets are not all multiples of four: indices, byte = 4 * index
`define PWMCT_IDX_WAKE 6'h10
`define PWMCT_IDX_CMPSTAT 6'h15
`define PWMCT_IDX_CMPMASK 6'h1b
`define PWMCT_IDX_CMPCTRL 6'h3b
`define PWMCT_IDX_CHCTRL 6'h20
`define PWMCT_IDX_PRDL 6'h21
`define PWMCT_IDX_PRDH 6'h22
`define PWMCT_IDX_DTYL 6'h23
`define PWMCT_IDX_DTYH 6'h24
`define PWMCT_IDX_DEADT 6'h25
`define PWMCT_IDX_TMRFLAG 6'h26
`define PWMCT_IDX_CNT 6'h27
`define PWMCT_IDX_CPU 6'h28

// channel control fields
`define PWMCT_CH_OUTEN 7
`define PWMCT_CH_INVEN 6
`define PWMCT_CH_ACTLOW 5
`define PWMCT_CH_RUN 3
`define PWMCT_CH_PRE_HI 2
`define PWMCT_CH_PRE_LO 0
// writable bits of the channel control register
`define PWMCT_CH_WMASK 8'hef

// comparator control fields
`define PWMCT_CC_REFSEL 7
`define PWMCT_CC_RESULT 6
`define PWMCT_CC_FUNC_HI 5
`define PWMCT_CC_FUNC_LO 4
`define PWMCT_CC_TRIPB 0
// writable bits of the comparator control register; result is read-only
`define PWMCT_CC_WMASK 8'hb1

// single-bit registers use bit 7
`define PWMCT_B7 7

// timer flag register fields
`define PWMCT_TF_PERIOD 0
`define PWMCT_TF_COMPARE 1

// cpu register fields
`define PWMCT_CPU_GIE 0
`define PWMCT_CPU_SLEEP 1

// reset values
`define PWMCT_RST_8 8'h00
`define PWMCT_RST_16 16'h0000
`define PWMCT_RST_PRD 16'hffff

`endif

// ===== pwmct_prescaler.v
/*
 pwmct_prescaler.v: divides the system clock by 2^sel and emits a
 one-cycle tick per prescaled period.
 assumes: clk_sys, synchronous active-low reset.
*/
module pwmct_prescaler #(
  parameter W = 8
) (
  input wire clk_sys,
  input wire resetn,
  input wire run,
  input wire [2:0] sel,
  output wire tick
);
  reg [W-1:0] div_r;
  wire [W-1:0] mask;

  assign mask = ({{(W-1){1'b0}}, 1'b1} << sel) - {{(W-1){1'b0}}, 1'b1};
  assign tick = run && ((div_r & mask) == {W{1'b0}});

  always @(posedge clk_sys)
  begin
    if (!resetn || !run)
      div_r <= {W{1'b0}};
    else
      div_r <= div_r + {{(W-1){1'b0}}, 1'b1};
  end
endmodule

// ===== pwmct_top.v
/*
 pwmct_top.v: one 16-bit pwm channel with prescaled up-counter, period
 and duty registers, duty latch, and the digital side of a comparator
 (change flag, wake, falling-edge trip), reached over apb.
 assumes: clk_sys 200 mhz, synchronous active-low reset, comparator
 level synchronous to clk_sys, pclk is clk_sys.
*/
// Design decision made here: the APB interface to the registers.
// Operation
// RQ1 - sixteen-bit period register per channel
// RQ2 - counter clears tick after period match
// RQ3 - output goes high after period match
// RQ4 - period flag set after period match
// RQ5 - zero duty keeps output low
// RQ6 - cycle lasts period plus one ticks
// RQ7 - duty latched only when counter clears
// RQ8 - latch equals counter drives output low
// RQ9 - duty writes allowed any time
// RQ10 - high time equals latched duty ticks
// RQ11 - output change sets compare timer flag
// RQ12 - period low byte write commits settings
// RQ13 - software sets up, enables timer last
// RQ14 - comparator falling edge trips outputs
// RQ15 - comparator change sets interrupt flag
// RQ16 - comparator result readable
// RQ17 - comparator flag cleared only by software
// RQ18 - irq needs enable and global enable
// RQ19 - wake on change with both enables
// RQ20 - two-bit comparator pin function field
// RQ21 - sixteen-bit counter, three-bit prescaler
// RQ22 - run enable clear stops counter
// RQ23 - active level inverts, inverted complements
`include "pwmct_defines.vh"

module pwmct_top #(
  parameter CW = 16,
  parameter PW = 8
) (
  input wire clk_sys,
  input wire resetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire comparator_output,
  output wire pwm_out,
  output wire pwm_out_inverted,
  output wire [1:0] cmp_pin_function,
  output wire cmp_irq,
  output wire cmp_wake
);
  reg [7:0] ch_ctrl_r;
  reg [7:0] cmp_ctrl_r;
  reg cmp_wake_enable_r;
  reg cmp_irq_enable_r;
  reg cmp_irq_flag_r;
  reg gie_r;
  reg sleep_r;
  reg [CW-1:0] period_reg_r;
  reg [CW-1:0] duty_reg_r;
  reg [7:0] dead_reg_r;
  reg [CW-1:0] prd_act_r;
  reg [CW-1:0] duty_latch_r;
  reg [7:0] dead_act_r;
  reg commit_r;
  reg [CW-1:0] pwm_up_counter_r;
  reg wave_r;
  reg period_match_flag_r;
  reg compare_timer_flag_r;
  reg cmp_prev_r;
  reg trip_r;
  reg [31:0] prdata_r;
  reg [31:0] rd_nxt;

  wire tick;
  wire acc;
  wire wr;
  wire rd;
  wire [5:0] idx;
  wire prd_hit;
  wire duty_hit;
  wire cmp_change;
  wire cmp_fall;
  wire out_en;
  wire inv_en;
  wire act_low;
  wire run;
  wire [CW-1:0] cnt_inc;
  wire wave_set;

  // word index from a byte address; unaligned bits ignored
  function [5:0] word_idx;
    input [7:0] a;
    begin
      word_idx = a[7:2];
    end
  endfunction

  // true when a write to the given index is taken
  function wr_hit;
    input [5:0] i;
    input [5:0] want;
    input w;
    begin
      wr_hit = w && (i == want);
    end
  endfunction

  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign idx = word_idx(paddr);
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = prdata_r;

  assign out_en = ch_ctrl_r[`PWMCT_CH_OUTEN];
  assign inv_en = ch_ctrl_r[`PWMCT_CH_INVEN];
  assign act_low = ch_ctrl_r[`PWMCT_CH_ACTLOW];
  assign run = ch_ctrl_r[`PWMCT_CH_RUN];

  // prescaled tick; held off while the timer is stopped
  pwmct_prescaler #(
    .W(PW)
  ) u_pre (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .run(run), // see RQ22
    .sel(ch_ctrl_r[`PWMCT_CH_PRE_HI:`PWMCT_CH_PRE_LO]), // see RQ21
    .tick(tick)
  );

  // next counter value, shared by the increment and the duty compare
  assign cnt_inc = pwm_up_counter_r + {{(CW-1){1'b0}}, 1'b1};
  assign prd_hit = tick && (pwm_up_counter_r == prd_act_r);
  // low from the tick on which the counter reaches the latch (see RQ8)
  assign duty_hit = tick && !prd_hit && (cnt_inc == duty_latch_r);
  // level taken at a period match, from the duty in force from then on
  assign wave_set = commit_r ? (duty_reg_r != `PWMCT_RST_16)
    : (duty_latch_r != `PWMCT_RST_16);

  // register writes
  always @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      ch_ctrl_r <= `PWMCT_RST_8;
      cmp_ctrl_r <= `PWMCT_RST_8;
      cmp_wake_enable_r <= 1'b0;
      cmp_irq_enable_r <= 1'b0;
      gie_r <= 1'b0;
      sleep_r <= 1'b0;
      period_reg_r <= `PWMCT_RST_PRD; // see RQ1
      duty_reg_r <= `PWMCT_RST_16;
      dead_reg_r <= `PWMCT_RST_8;
    end
    else
    begin
      if (wr_hit(idx, `PWMCT_IDX_CHCTRL, wr))
        ch_ctrl_r <= pwdata[7:0] & `PWMCT_CH_WMASK;
      if (wr_hit(idx, `PWMCT_IDX_CMPCTRL, wr))
        cmp_ctrl_r <= pwdata[7:0] & `PWMCT_CC_WMASK;
      if (wr_hit(idx, `PWMCT_IDX_WAKE, wr))
        cmp_wake_enable_r <= pwdata[`PWMCT_B7];
      if (wr_hit(idx, `PWMCT_IDX_CMPMASK, wr))
        cmp_irq_enable_r <= pwdata[`PWMCT_B7];
      // sleep request; a comparator wake ends it
      if (wr_hit(idx, `PWMCT_IDX_CPU, wr))
      begin
        gie_r <= pwdata[`PWMCT_CPU_GIE];
        sleep_r <= pwdata[`PWMCT_CPU_SLEEP];
      end
      else if (sleep_r && cmp_wake)
        sleep_r <= 1'b0;
      if (wr_hit(idx, `PWMCT_IDX_PRDL, wr))
        period_reg_r[7:0] <= pwdata[7:0];
      if (wr_hit(idx, `PWMCT_IDX_PRDH, wr))
        period_reg_r[15:8] <= pwdata[7:0];
      if (wr_hit(idx, `PWMCT_IDX_DTYL, wr))
        duty_reg_r[7:0] <= pwdata[7:0]; // see RQ9
      if (wr_hit(idx, `PWMCT_IDX_DTYH, wr))
        duty_reg_r[15:8] <= pwdata[7:0]; // see RQ9
      if (wr_hit(idx, `PWMCT_IDX_DEADT, wr))
        dead_reg_r <= pwdata[7:0];
    end
  end

  // commit pending after period low byte write (see RQ12)
  always @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      commit_r <= 1'b1;
      // zero active period: the first tick after setup commits at once
      prd_act_r <= `PWMCT_RST_16;
      dead_act_r <= `PWMCT_RST_8;
    end
    else
    begin
      if (wr_hit(idx, `PWMCT_IDX_PRDL, wr))
        commit_r <= 1'b1;
      else if (prd_hit)
        commit_r <= 1'b0;
      if (prd_hit && commit_r)
      begin
        prd_act_r <= period_reg_r; // see RQ12
        dead_act_r <= dead_reg_r;
      end
    end
  end

  // counter, duty latch and waveform
  always @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      pwm_up_counter_r <= `PWMCT_RST_16;
      duty_latch_r <= `PWMCT_RST_16;
      wave_r <= 1'b0;
    end
    else if (prd_hit)
    begin
      pwm_up_counter_r <= `PWMCT_RST_16; // see RQ2 RQ6
      wave_r <= wave_set; // see RQ3 RQ5
      if (commit_r)
        duty_latch_r <= duty_reg_r; // see RQ7
    end
    else if (tick)
    begin
      pwm_up_counter_r <= cnt_inc;
      if (duty_hit)
        wave_r <= 1'b0; // see RQ8 RQ10
    end
  end

  // timer flags: set wins over software clear
  always @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      period_match_flag_r <= 1'b0;
      compare_timer_flag_r <= 1'b0;
    end
    else
    begin
      if (prd_hit)
        period_match_flag_r <= 1'b1; // see RQ4
      else if (wr_hit(idx, `PWMCT_IDX_TMRFLAG, wr)
               && pwdata[`PWMCT_TF_PERIOD])
        period_match_flag_r <= 1'b0;
      if ((prd_hit && (wave_set != wave_r)) || (duty_hit && wave_r))
        compare_timer_flag_r <= 1'b1; // see RQ11
      else if (wr_hit(idx, `PWMCT_IDX_TMRFLAG, wr)
               && pwdata[`PWMCT_TF_COMPARE])
        compare_timer_flag_r <= 1'b0;
    end
  end

  assign cmp_change = comparator_output != cmp_prev_r;
  assign cmp_fall = cmp_prev_r && !comparator_output;

  // comparator digital side
  always @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      // follows the pin in reset, so release shows no false edge
      cmp_prev_r <= comparator_output;
      cmp_irq_flag_r <= 1'b0;
      trip_r <= 1'b0;
    end
    else
    begin
      cmp_prev_r <= comparator_output;
      // cleared by writing zero; a change in the same cycle wins
      if (cmp_change)
        cmp_irq_flag_r <= 1'b1; // see RQ15 RQ17
      else if (wr_hit(idx, `PWMCT_IDX_CMPSTAT, wr)
               && !pwdata[`PWMCT_B7])
        cmp_irq_flag_r <= 1'b0;
      // trip holds until software rewrites the comparator control
      if (cmp_fall && (out_en || inv_en))
        trip_r <= 1'b1; // see RQ14
      else if (wr_hit(idx, `PWMCT_IDX_CMPCTRL, wr))
        trip_r <= 1'b0;
    end
  end

  // see RQ14 RQ23
  assign pwm_out = out_en && !trip_r && (wave_r ^ act_low);
  assign pwm_out_inverted = inv_en
    && !(trip_r && cmp_ctrl_r[`PWMCT_CC_TRIPB])
    && !(wave_r ^ act_low);
  assign cmp_pin_function =
    cmp_ctrl_r[`PWMCT_CC_FUNC_HI:`PWMCT_CC_FUNC_LO]; // see RQ20
  assign cmp_irq = cmp_irq_flag_r && cmp_irq_enable_r && gie_r; // see RQ18
  assign cmp_wake = cmp_irq_flag_r && cmp_irq_enable_r
    && cmp_wake_enable_r && sleep_r; // see RQ19

  // read mux
  always @*
  begin
    rd_nxt = 32'h00000000;
    case (idx)
      `PWMCT_IDX_WAKE: rd_nxt[`PWMCT_B7] = cmp_wake_enable_r;
      `PWMCT_IDX_CMPSTAT: rd_nxt[`PWMCT_B7] = cmp_irq_flag_r;
      `PWMCT_IDX_CMPMASK: rd_nxt[`PWMCT_B7] = cmp_irq_enable_r;
      `PWMCT_IDX_CMPCTRL:
      begin
        rd_nxt[7:0] = cmp_ctrl_r;
        rd_nxt[`PWMCT_CC_RESULT] = cmp_prev_r; // see RQ16
      end
      `PWMCT_IDX_CHCTRL: rd_nxt[7:0] = ch_ctrl_r;
      `PWMCT_IDX_PRDL: rd_nxt[7:0] = period_reg_r[7:0];
      `PWMCT_IDX_PRDH: rd_nxt[7:0] = period_reg_r[15:8];
      `PWMCT_IDX_DTYL: rd_nxt[7:0] = duty_reg_r[7:0];
      `PWMCT_IDX_DTYH: rd_nxt[7:0] = duty_reg_r[15:8];
      `PWMCT_IDX_DEADT: rd_nxt[7:0] = dead_reg_r;
      `PWMCT_IDX_TMRFLAG:
      begin
        rd_nxt[`PWMCT_TF_PERIOD] = period_match_flag_r;
        rd_nxt[`PWMCT_TF_COMPARE] = compare_timer_flag_r;
      end
      `PWMCT_IDX_CNT: rd_nxt[15:0] = pwm_up_counter_r;
      `PWMCT_IDX_CPU:
      begin
        rd_nxt[`PWMCT_CPU_GIE] = gie_r;
        rd_nxt[`PWMCT_CPU_SLEEP] = sleep_r;
      end
      default: rd_nxt = 32'h00000000;
    endcase
  end

  // read data captured in setup phase, valid through access phase
  always @(posedge clk_sys)
  begin
    if (!resetn)
      prdata_r <= 32'h00000000;
    else if (psel && !penable && !pwrite)
      prdata_r <= rd_nxt;
  end
endmodule

// ===== pwmct_props.sv
/* pwmct_props: port-level assertions on pwmct_top.
 assumes: one clock clk_sys, synchronous active-low resetn. */
module pwmct_props (
  input wire clk_sys,
  input wire resetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire comparator_output,
  input wire pwm_out,
  input wire pwm_out_inverted,
  input wire [1:0] cmp_pin_function,
  input wire cmp_irq,
  input wire cmp_wake
);
  logic wr;
  logic cq;
  logic [2:0] age;
  assign wr = psel & penable & pwrite;
  // cycles since the last comparator change or register write
  always @(posedge clk_sys)
  begin
    cq <= comparator_output;
    if (!resetn)
      age <= 3'h7;
    else if (wr || cq != comparator_output)
      age <= 3'h0;
    else if (age != 3'h7)
      age <= age + 3'h1;
  end
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  pready_high_a: assert property (pready)
    else $error("pready low");
  no_slverr_a: assert property (!pslverr)
    else $error("pslverr high");
  reset_quiet_a: assert property (disable iff (1'b0) !resetn |=>
    !pwm_out && !cmp_irq && !cmp_wake && prdata == 32'h0)
    else $error("outputs not quiet after reset");
  irq_hold_a: assert property (cmp_irq && !wr |=> cmp_irq)
    else $error("comparator irq dropped without a write");
  irq_cause_a: assert property ($rose(cmp_irq) |-> age<=3'h4)
    else $error("comparator irq rose without a cause");
  wake_cause_a: assert property ($rose(cmp_wake) |-> age <= 3'h4)
    else $error("wake rose without a cause");
  func_hold_a: assert property (!wr |=> $stable(cmp_pin_function))
    else $error("pin function changed without a write");
  both_out_a: assert property (!(pwm_out && pwm_out_inverted))
    else $error("both pwm outputs high");
  rdata_hold_a: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("read data changed outside a setup");
endmodule
bind pwmct_top pwmct_props i_props (.clk_sys(clk_sys), .resetn(resetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pwm_out(pwm_out),
  .pwm_out_inverted(pwm_out_inverted),
  .comparator_output(comparator_output), .cmp_irq(cmp_irq),
  .cmp_pin_function(cmp_pin_function), .cmp_wake(cmp_wake));

// ===== pwmct_load.sv
/* pwmct_load: power stage model; measures pulses, senses overload.
 assumes: shares clk_sys with the top; fault is set by the bench. */
module pwmct_load (
  input wire clk_sys,
  input wire pwm_out,
  input wire pwm_out_inverted,
  input wire fault,
  output logic comparator_output,
  output logic [31:0] hi_w,
  output logic [31:0] per_w,
  output logic [31:0] n_hi
);
  timeunit 1ns;
  timeprecision 1ps;
  logic q = 1'b0;
  logic [31:0] h = 0;
  logic [31:0] p = 0;
  initial comparator_output = 1'b1;
  initial {hi_w, per_w, n_hi} = 96'h0;
  // overload drops the sense comparator, synchronous to clk_sys
  always @(posedge clk_sys)
  begin
    comparator_output <= !fault;
    q <= pwm_out;
    n_hi <= n_hi + pwm_out;
    p <= (pwm_out && !q) ? 1 : p + 1;
    h <= (pwm_out && !q) ? 1 : h + pwm_out;
    if (pwm_out && !q)
      per_w <= p;
    if (!pwm_out && q)
      hi_w <= h;
  end
endmodule

// ===== pwmct_top_tb.sv
/* pwmct_top_tb: self-checking bench of pwmct_top over apb.
 assumes: pwmct_load on the pwm side, pwmct_props bound in. */
`include "pwmct_defines.vh"
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin \
  n_fail++; $display("Error %s exp %0h got %0h", n, e, s); end end
module pwmct_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, resetn, psel, penable, pwrite, fault;
  logic [7:0] paddr;
  logic [31:0] pwdata, rdat, seed;
  wire [31:0] prdata, hi_w, per_w, n_hi;
  wire pready, pslverr, comparator_output, pwm_out, pwm_out_inverted;
  wire cmp_irq, cmp_wake;
  wire [1:0] cmp_pin_function;
  int n_fail, check_count, cyc, p, d, k, m;
  pwmct_top i_dut (.clk_sys(clk_sys), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .comparator_output(comparator_output), .pwm_out(pwm_out),
    .pwm_out_inverted(pwm_out_inverted), .cmp_wake(cmp_wake),
    .cmp_pin_function(cmp_pin_function), .cmp_irq(cmp_irq));
  pwmct_load i_load (.clk_sys(clk_sys), .pwm_out(pwm_out),
    .pwm_out_inverted(pwm_out_inverted), .fault(fault), .n_hi(n_hi),
    .comparator_output(comparator_output), .hi_w(hi_w), .per_w(per_w));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic apb(input logic w, input logic [5:0] i, input logic [7:0] v);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {24'h0, v};
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
      @(posedge clk_sys);
    rdat = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // old cycle may still run out before the new settings land
  task automatic waitp();
    repeat (((4 * (p + 1)) << k) + 80) @(posedge clk_sys);
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      n_fail++;
      stop_test();
    end
  end
  initial
  begin
    {resetn, psel, penable, pwrite, fault, paddr, pwdata} = 0;
    seed = 32'ha92e;
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    apb(1'b0, `PWMCT_IDX_PRDL, 8'h0);
    `CHK("period low", 8'hff, rdat[7:0])
    apb(1'b0, 6'h3f, 8'h0);
    `CHK("unmapped", 32'h0, rdat)
    for (k = 0; k < 3; k++)
    begin
      p = 8 + xs() % 24;
      d = 1 + xs() % (p - 2);
      apb(1'b1, `PWMCT_IDX_DTYH, 8'h0);
      apb(1'b1, `PWMCT_IDX_DTYL, d[7:0]);
      apb(1'b1, `PWMCT_IDX_PRDH, 8'h0);
      apb(1'b1, `PWMCT_IDX_PRDL, p[7:0]);
      apb(1'b1, `PWMCT_IDX_CHCTRL, 8'h88 | k[7:0]);
      waitp();
      `CHK("high width", d << k, hi_w)
      `CHK("cycle width", (p + 1) << k, per_w)
    end
    // prescale of the last pass stays in force
    k = k - 1;
    apb(1'b0, `PWMCT_IDX_TMRFLAG, 8'h0);
    `CHK("timer flags", 2'b11, rdat[1:0])
    apb(1'b1, `PWMCT_IDX_DTYL, d[7:0] + 8'h1);
    waitp();
    `CHK("duty before commit", d << k, hi_w)
    apb(1'b1, `PWMCT_IDX_PRDL, p[7:0]);
    waitp();
    `CHK("duty after commit", (d + 1) << k, hi_w)
    apb(1'b1, `PWMCT_IDX_DTYL, 8'h0);
    apb(1'b1, `PWMCT_IDX_PRDL, p[7:0]);
    waitp();
    m = n_hi;
    waitp();
    `CHK("zero duty", m, n_hi)
    apb(1'b1, `PWMCT_IDX_DTYL, d[7:0]);
    apb(1'b1, `PWMCT_IDX_PRDL, p[7:0]);
    apb(1'b1, `PWMCT_IDX_CMPMASK, 8'h80);
    apb(1'b1, `PWMCT_IDX_CPU, 8'h01);
    apb(1'b1, `PWMCT_IDX_CMPCTRL, 8'h20);
    @(negedge clk_sys);
    `CHK("pin function", 2'b10, cmp_pin_function)
    waitp();
    fault <= 1'b1;
    waitp();
    m = n_hi;
    `CHK("irq on fall", 1'b1, cmp_irq)
    waitp();
    `CHK("tripped", m, n_hi)
    apb(1'b0, `PWMCT_IDX_CMPCTRL, 8'h0);
    `CHK("result low", 1'b0, rdat[6])
    apb(1'b1, `PWMCT_IDX_CMPSTAT, 8'h0);
    fault <= 1'b0;
    @(negedge clk_sys);
    `CHK("flag cleared", 1'b0, cmp_irq)
    repeat (8) @(negedge clk_sys);
    `CHK("irq on rise", 1'b1, cmp_irq)
    apb(1'b0, `PWMCT_IDX_CMPCTRL, 8'h0);
    `CHK("result high", 1'b1, rdat[6])
    apb(1'b1, `PWMCT_IDX_CPU, 8'h00);
    @(negedge clk_sys);
    `CHK("irq masked", 1'b0, cmp_irq)
    apb(1'b1, `PWMCT_IDX_CMPCTRL, 8'h20);
    waitp();
    m = n_hi;
    waitp();
    `CHK("trip released", 1'b1, n_hi > m)
    apb(1'b1, `PWMCT_IDX_CHCTRL, 8'hc8 | k[7:0]);
    repeat ((p + 1) << k)
    begin
      @(negedge clk_sys);
      `CHK("inverted", !pwm_out, pwm_out_inverted)
    end
    apb(1'b1, `PWMCT_IDX_CHCTRL, 8'ha8 | k[7:0]);
    waitp();
    `CHK("active low width", (p + 1 - d) << k, hi_w)
    apb(1'b1, `PWMCT_IDX_CHCTRL, 8'h80 | k[7:0]);
    apb(1'b0, `PWMCT_IDX_CNT, 8'h0);
    m = rdat;
    apb(1'b0, `PWMCT_IDX_CNT, 8'h0);
    `CHK("counter stopped", m, rdat)
    apb(1'b1, `PWMCT_IDX_CMPSTAT, 8'h0);
    apb(1'b1, `PWMCT_IDX_WAKE, 8'h80);
    apb(1'b1, `PWMCT_IDX_CPU, 8'h02);
    fault <= 1'b1;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    `CHK("wake pulse", 1'b1, cmp_wake)
    apb(1'b0, `PWMCT_IDX_CPU, 8'h0);
    `CHK("woken", 1'b0, rdat[1])
    stop_test();
  end
endmodule
